//--- ebs_pkg.sv
// package: constants and types for the external bus strobe block
package ebs_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int CS_N   = 4;
  // ---------------------------------------------------------------
  // timing: phase lengths in core_clk cycles
  // ---------------------------------------------------------------
  // 8 ns latch and 12 ns strobe at a 4 ns clock, rounded up
  localparam int  LATCH_CYC    = 2;
  localparam int  STROBE_CYC   = 3;
  localparam logic [3:0] CNT_RST = 4'h0;
  // edges after release before the synchronised straps are valid
  localparam logic [1:0] STRAP_WAIT = 2'h2;
  // ---------------------------------------------------------------
  // bus sequencer states, gray along the access path from idle through to recovery
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    EBS_IDLE   = 3'b000,
    EBS_LATCH  = 3'b001,
    EBS_SETUP  = 3'b011,
    EBS_STROBE = 3'b010,
    EBS_RECOV  = 3'b110,
    EBS_HOLD   = 3'b100
  } ebs_state_t;
endpackage : ebs_pkg

//--- ebs_sync.sv
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module ebs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] stage1_r;
  // first flop is read only by the second
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      stage1_r <= RST_VAL;
      syncOut  <= RST_VAL;
    end else begin
      stage1_r <= asyncIn;
      syncOut  <= stage1_r;
    end
  end
endmodule : ebs_sync

//--- ebs_lane_decode.sv
// combinational strobe and lane decode for one access
`timescale 1ns/1ps
module ebs_lane_decode (
  input  wire logic strobeOn,
  input  wire logic isWrite,
  input  wire logic addrOdd,
  input  wire logic wordAccess,
  input  wire logic singleWrite,
  output logic      readStrobeN,
  output logic      lowerStoreN,
  output logic      upperStoreN
);
  // strobe pins decoded from scheme and parity
  always_comb begin
    readStrobeN = !(strobeOn && !isWrite);
    if (singleWrite) begin
      lowerStoreN = !(strobeOn && isWrite);
      upperStoreN = !(strobeOn && (addrOdd || wordAccess));
    end else begin
      lowerStoreN = !(strobeOn && isWrite && (!addrOdd || wordAccess));
      upperStoreN = !(strobeOn && isWrite && (addrOdd || wordAccess));
    end
  end
endmodule : ebs_lane_decode

//--- ebs_bus_strobes.sv
// external memory bus sequencer: address, strobes, latch, hold and wait
`timescale 1ns/1ps
module ebs_bus_strobes #(
  parameter int LATCH_CYC  = ebs_pkg::LATCH_CYC,
  parameter int STROBE_CYC = ebs_pkg::STROBE_CYC
) (
  input  wire logic                      core_clk,
  input  wire logic                      reset_n,
  // board straps and handshakes (pins)
  input  wire logic                      boot_mode_pin,
  input  wire logic                      laneWidthPin,
  input  wire logic                      busReleaseReqN,
  input  wire logic                      readyN,
  // configuration
  input  wire logic                      muxedBus,
  input  wire logic                      singleWrite,
  // core request side
  input  wire logic                      reqValid,
  output logic                           reqReady,
  input  wire logic                      reqWrite,
  input  wire logic                      reqWord,
  input  wire logic [ebs_pkg::ADDR_W-1:0] reqAddr,
  input  wire logic [ebs_pkg::DATA_W-1:0] reqWdata,
  input  wire logic [1:0]                reqRegion,
  output logic                           rspValid,
  output logic [ebs_pkg::DATA_W-1:0]     rspRdata,
  // status
  output logic                           microprocMode,
  output logic                           narrowBus,
  // pins
  output logic [ebs_pkg::ADDR_W-1:0]     addrOut,
  input  wire logic [ebs_pkg::DATA_W-1:0] dataIn,
  output logic [ebs_pkg::DATA_W-1:0]     dataOut,
  output logic [ebs_pkg::DATA_W-1:0]     dataOeN,
  output logic [ebs_pkg::CS_N-1:0]       region_select_n,
  output logic                           readStrobeN,
  output logic                           lower_lane_store_n,
  output logic                           upper_lane_store_n,
  output logic                           upper_lane_enable_n,
  output logic                           addrLatch,
  output logic                           bus_release_ack_n
);
  // ---------------------------------------------------------------
  // state record
  // ---------------------------------------------------------------
  typedef struct packed {
    ebs_pkg::ebs_state_t           state;
    logic [3:0]                    cnt;
    logic                          write;
    logic                          word;
    logic                          narrow;
    logic                          microproc;
    logic                          strapDone;
    logic [1:0]                    strapCnt;
    logic [ebs_pkg::ADDR_W-1:0]    addr;
    logic [ebs_pkg::DATA_W-1:0]    wdata;
    logic [ebs_pkg::CS_N-1:0]      csN;
    logic                          ale;
    logic                          rvalid;
    logic [ebs_pkg::DATA_W-1:0]    rdata;
    logic [ebs_pkg::DATA_W-1:0]    oeN;
    logic [ebs_pkg::DATA_W-1:0]    dout;
    logic                          ackN;
  } ebs_regs_t;

  ebs_regs_t st_r;
  ebs_regs_t st_nxt;

  logic [3:0] syncQ;
  logic       bootS;
  logic       widthS;
  logic       holdReqN;
  logic       waitReqN;
  logic       strobeOn;
  logic       addrOdd;
  logic       laneUpperN;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  ebs_sync #(
    .W       (4),
    .RST_VAL (4'hc)
  ) u_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .asyncIn  ({busReleaseReqN, readyN, boot_mode_pin, laneWidthPin}),
    .syncOut  (syncQ)
  );
  assign holdReqN = syncQ[3];
  assign waitReqN = syncQ[2];
  assign bootS    = syncQ[1];
  assign widthS   = syncQ[0];

  // ---------------------------------------------------------------
  // strobe decode
  // ---------------------------------------------------------------
  assign strobeOn = (st_r.state == ebs_pkg::EBS_STROBE);
  assign addrOdd  = st_r.addr[0];

  // word access only on a 16-bit bus with an even address
  ebs_lane_decode u_lane (
    .strobeOn    (strobeOn),
    .isWrite     (st_r.write),
    .addrOdd     (addrOdd),
    .wordAccess  (st_r.word),
    .singleWrite (singleWrite),
    .readStrobeN (readStrobeN),
    .lowerStoreN (lower_lane_store_n),
    .upperStoreN (laneUpperN)
  );

  // the shared pin carries the high store or the upper enable
  always_comb begin
    if (singleWrite) begin
      upper_lane_enable_n = !((strobeOn || st_r.state == ebs_pkg::EBS_SETUP)
                              && (addrOdd || st_r.word));
    end else begin
      upper_lane_enable_n = laneUpperN;
    end
  end
  assign upper_lane_store_n = upper_lane_enable_n;

  // ---------------------------------------------------------------
  // pin outputs from state
  // ---------------------------------------------------------------
  assign addrOut           = st_r.addr;
  assign region_select_n   = st_r.csN;
  assign addrLatch         = st_r.ale;
  assign dataOut           = st_r.dout;
  assign dataOeN           = st_r.oeN;
  assign bus_release_ack_n = st_r.ackN;
  assign rspValid          = st_r.rvalid;
  assign rspRdata          = st_r.rdata;
  assign microprocMode     = st_r.microproc;
  assign narrowBus         = st_r.narrow;
  // requests only start from idle once straps are caught
  assign reqReady = (st_r.state == ebs_pkg::EBS_IDLE) && st_r.strapDone && holdReqN;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = 1'b0;
    // straps caught once after release; width must stay fixed
    // the synchroniser still shows its reset value for two edges
    if (!st_r.strapDone) begin
      if (st_r.strapCnt == ebs_pkg::STRAP_WAIT) begin
        st_nxt.strapDone = 1'b1;
        st_nxt.microproc = bootS;
        st_nxt.narrow    = widthS;
      end else begin
        st_nxt.strapCnt = st_r.strapCnt + 2'h1;
      end
    end
    unique case (st_r.state)
      ebs_pkg::EBS_IDLE: begin
        st_nxt.csN  = '1;
        st_nxt.oeN  = '1;
        st_nxt.ackN = 1'b1;
        if (!holdReqN) begin
          st_nxt.state = ebs_pkg::EBS_HOLD;
          st_nxt.ackN  = 1'b0;
        end else if (reqValid && st_r.strapDone) begin
          st_nxt.state = ebs_pkg::EBS_LATCH;
          st_nxt.cnt   = 4'(LATCH_CYC - 1);
          st_nxt.write = reqWrite;
          st_nxt.word  = reqWord && !st_r.narrow && !reqAddr[0];
          st_nxt.addr  = reqAddr;
          st_nxt.wdata = reqWdata;
          st_nxt.csN   = ~(4'h1 << reqRegion);
          st_nxt.ale   = muxedBus;
          if (muxedBus) begin
            st_nxt.oeN = {8'hff, 8'h00};
            // shared low lines carry address first
            st_nxt.dout = st_r.narrow ? {8'h00, reqAddr[7:0]}
                                      : {8'h00, reqAddr[8:1]};
          end
        end
      end
      ebs_pkg::EBS_LATCH: begin
        if (st_r.cnt == ebs_pkg::CNT_RST) begin
          st_nxt.state = ebs_pkg::EBS_SETUP;
          st_nxt.ale   = 1'b0;
        end else begin
          st_nxt.cnt = st_r.cnt - 4'h1;
        end
      end
      ebs_pkg::EBS_SETUP: begin
        // data lines switch only after the latch pulse has ended
        st_nxt.state = ebs_pkg::EBS_STROBE;
        st_nxt.cnt   = 4'(STROBE_CYC - 1);
        if (st_r.write) begin
          st_nxt.dout = st_r.wdata;
          st_nxt.oeN  = st_r.narrow ? {8'hff, 8'h00} : 16'h0000;
          if (!st_r.narrow && st_r.addr[0] && !st_r.word) begin
            st_nxt.dout = {st_r.wdata[7:0], st_r.wdata[7:0]};
          end
        end else begin
          st_nxt.oeN = '1;
        end
      end
      ebs_pkg::EBS_STROBE: begin
        if (st_r.cnt != ebs_pkg::CNT_RST) begin
          st_nxt.cnt = st_r.cnt - 4'h1;
        end else if (waitReqN) begin
          st_nxt.state = ebs_pkg::EBS_RECOV;
          if (!st_r.write) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = st_r.narrow ? {8'h00, dataIn[7:0]} : dataIn;
            if (!st_r.narrow && st_r.addr[0] && !st_r.word) begin
              st_nxt.rdata = {8'h00, dataIn[15:8]};
            end
          end
        end
      end
      ebs_pkg::EBS_RECOV: begin
        st_nxt.state = ebs_pkg::EBS_IDLE;
        st_nxt.csN   = '1;
        st_nxt.oeN   = '1;
      end
      ebs_pkg::EBS_HOLD: begin
        st_nxt.oeN = '1;
        st_nxt.csN = '1;
        if (holdReqN) begin
          st_nxt.state = ebs_pkg::EBS_IDLE;
          st_nxt.ackN  = 1'b1;
        end else begin
          st_nxt.ackN = 1'b0;
        end
      end
      default: begin
        st_nxt.state = ebs_pkg::EBS_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_r           <= '0;
      st_r.state     <= ebs_pkg::EBS_IDLE;
      st_r.csN       <= '1;
      st_r.oeN       <= '1;
      st_r.ackN      <= 1'b1;
      st_r.narrow    <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : ebs_bus_strobes

//--- ebs_bus_strobes_sva.sv
// checker: pin timing relations of the external bus sequencer
`timescale 1ns/1ps
module ebs_bus_strobes_sva (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        muxedBus,
  input wire logic        narrowBus,
  input wire logic        rspValid,
  input wire logic [19:0] addrOut,
  input wire logic [15:0] dataOut,
  input wire logic [15:0] dataOeN,
  input wire logic [3:0]  region_select_n,
  input wire logic        readStrobeN,
  input wire logic        lower_lane_store_n,
  input wire logic        upper_lane_store_n,
  input wire logic        addrLatch,
  input wire logic        bus_release_ack_n
);
  // one domain, so clock and reset are stated once
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_idle_high: assert property (&region_select_n |-> readStrobeN && lower_lane_store_n && upper_lane_store_n)
    else $error("strobe low while idle");
  a_one_region: assert property ($onehot0(~region_select_n))
    else $error("two selects low");
  a_read_width: assert property ($fell(readStrobeN) |-> !readStrobeN [*3])
    else $error("read strobe short");
  a_read_answer: assert property ($rose(readStrobeN) |-> rspValid ##1 !rspValid)
    else $error("read answer missing");
  a_store_width: assert property ($fell(lower_lane_store_n) |-> !lower_lane_store_n [*3])
    else $error("store strobe short");
  a_latch_pulse: assert property ($rose(addrLatch) |-> addrLatch [*2] ##1 !addrLatch)
    else $error("latch pulse length");
  a_latch_quiet: assert property (addrLatch |-> readStrobeN && lower_lane_store_n && !(&region_select_n))
    else $error("strobe during latch");
  a_mux_narrow: assert property (addrLatch && muxedBus && narrowBus
    |-> dataOut[7:0] == addrOut[7:0] && dataOeN[7:0] == 8'h00) else $error("narrow mux address");
  a_mux_wide: assert property (addrLatch && muxedBus && !narrowBus
    |-> dataOut[7:0] == addrOut[8:1] && dataOeN[7:0] == 8'h00) else $error("wide mux address");
  a_hold_quiet: assert property (!bus_release_ack_n |-> &region_select_n && readStrobeN)
    else $error("access during hold");
endmodule : ebs_bus_strobes_sva

//--- ebs_ext_mem.sv
// external memory model on the far side of the bus pins
`timescale 1ns/1ps
module ebs_ext_mem (
  input  wire logic        core_clk,
  input  wire logic [19:0] addrOut,
  input  wire logic [15:0] dataOut,
  input  wire logic        readStrobeN,
  input  wire logic        lower_lane_store_n,
  input  wire logic        upper_lane_store_n,
  input  wire logic        singleWrite,
  input  wire logic [3:0]  waitCyc,
  output logic      [15:0] dataIn,
  output logic             readyN
);
  logic [15:0] mem [0:255];
  logic [15:0] lastQ   = 16'h0000;
  logic [3:0]  waitCnt = 4'h0;
  logic        idleQ   = 1'b1;
  logic        idleN;
  logic [7:0]  wa;
  // released bus shows the inverse of the last word, never a stale copy
  assign idleN  = readStrobeN & lower_lane_store_n & upper_lane_store_n;
  assign wa     = addrOut[8:1];
  assign dataIn = readStrobeN ? ~lastQ : mem[wa];
  // waits start with the strobe so the pin synchroniser cannot miss them
  assign readyN = !((idleQ && !idleN && waitCyc != 4'h0) || waitCnt != 4'h0);
  // lane writes and wait counter
  always @(posedge core_clk) begin
    idleQ <= idleN;
    if (idleQ && !idleN) waitCnt <= waitCyc;
    else if (waitCnt != 4'h0) waitCnt <= waitCnt - 4'h1;
    if (!readStrobeN) lastQ <= mem[wa];
    if (!lower_lane_store_n && (!singleWrite || !addrOut[0])) mem[wa][7:0] <= dataOut[7:0];
    if (!upper_lane_store_n && (!singleWrite || !lower_lane_store_n)) mem[wa][15:8] <= dataOut[15:8];
  end
endmodule : ebs_ext_mem

//--- ebs_bus_strobes_tb.sv
// testbench: directed scenarios for the external bus sequencer
`timescale 1ns/1ps
module ebs_bus_strobes_tb;
  logic        core_clk = 1'b0, reset_n = 1'b0, boot_mode_pin = 1'b1, laneWidthPin = 1'b0, busReleaseReqN = 1'b1;
  logic        muxedBus = 1'b0, singleWrite = 1'b0, reqValid = 1'b0, reqWrite = 1'b0, reqWord = 1'b0;
  logic [19:0] reqAddr = 20'h00000, aSeen;
  logic [15:0] reqWdata = 16'h0000, rspRdata, dataIn, dataOut, dataOeN;
  logic [1:0]  reqRegion = 2'h0;
  logic [3:0]  waitCyc = 4'h0, region_select_n, csSeen;
  logic        reqReady, rspValid, microprocMode, narrowBus, readStrobeN, lower_lane_store_n, upper_lane_store_n;
  logic        upper_lane_enable_n, addrLatch, bus_release_ack_n, readyN, sawRd, sawLo, sawUe, sawAle;
  int          rdLen, miscompares = 0, totalChecks = 0;

  wire logic [19:0] aOutW;
  ebs_bus_strobes u_dut (.core_clk, .reset_n, .boot_mode_pin, .laneWidthPin, .busReleaseReqN, .readyN, .muxedBus,
    .singleWrite, .reqValid, .reqReady, .reqWrite, .reqWord, .reqAddr, .reqWdata, .reqRegion, .rspValid, .rspRdata,
    .microprocMode, .narrowBus, .addrOut(aOutW), .dataIn, .dataOut, .dataOeN, .region_select_n, .readStrobeN,
    .lower_lane_store_n, .upper_lane_store_n, .upper_lane_enable_n, .addrLatch, .bus_release_ack_n);
  ebs_ext_mem u_mem (.core_clk, .addrOut(aOutW), .dataOut, .readStrobeN, .lower_lane_store_n, .upper_lane_store_n,
    .singleWrite, .waitCyc, .dataIn, .readyN);

  // 250 MHz clock
  initial forever #2 core_clk = ~core_clk;

  // access monitor, cleared by each request except aSeen
  always @(posedge core_clk) begin
    rdLen  <= rdLen + int'(!readStrobeN);
    sawRd  <= sawRd | !readStrobeN;
    sawLo  <= sawLo | !lower_lane_store_n;
    sawUe  <= sawUe | !upper_lane_enable_n;
    sawAle <= sawAle | addrLatch;
    csSeen <= csSeen & region_select_n;
    if (region_select_n != 4'hf) aSeen <= aOutW;
  end

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("checks=%0d miscompares=%0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim

  // bounded wait that ran out ends the run
  task automatic tmo(input int n);
    if (n >= 80) begin
      miscompares++;
      end_sim();
    end
  endtask : tmo

  // one access: hold the request until taken, then drain back to idle
  task automatic access(input logic w, input logic wd, input logic [19:0] a, input logic [15:0] d, input logic [1:0] r);
    int n = 0;
    @(negedge core_clk);
    {reqWrite, reqWord, reqAddr, reqWdata, reqRegion, reqValid} = {w, wd, a, d, r, 1'b1};
    {sawRd, sawLo, sawUe, sawAle, csSeen, rdLen} = {4'h0, 4'hf, 32'h0};
    // ready looked at off the edge; the next rising edge takes the request
    while (reqReady !== 1'b1 && n < 80) begin @(negedge core_clk); n++; end
    tmo(n);
    @(negedge core_clk) reqValid = 1'b0;
    do begin @(negedge core_clk); n++; end while (!(reqReady === 1'b1 && region_select_n === 4'hf) && n < 80);
    tmo(n);
  endtask : access

  task automatic t_reset;
    check(microprocMode, 1'b1);
    check(narrowBus, 1'b0);
    check({region_select_n, readStrobeN, lower_lane_store_n, bus_release_ack_n}, 7'h7f);
    $display("test reset done");
  endtask : t_reset

  task automatic t_lanes;
    for (int r = 0; r < 4; r++) begin
      access(1'b1, 1'b0, 20'hab120 + 20'(r), {2{8'h30 + 8'(r)}}, 2'(r));
      check(sawLo, !r[0]);
      check(sawUe, r[0]);
      check(csSeen, 4'(~(4'h1 << r)));
      check(aSeen, 20'hab120 + 20'(r));
    end
    access(1'b0, 1'b1, 20'hab122, 16'h0000, 2'h0);
    check(rspRdata, 16'h3332);
    $display("test byte lanes done");
  endtask : t_lanes

  task automatic t_single;
    singleWrite = 1'b1;
    access(1'b1, 1'b0, 20'hab127, 16'hc7c7, 2'h1);
    check({sawRd, sawLo, sawUe}, 3'b011);
    access(1'b1, 1'b0, 20'hab126, 16'h9696, 2'h1);
    check({sawRd, sawLo, sawUe}, 3'b010);
    access(1'b0, 1'b0, 20'hab127, 16'h0000, 2'h1);
    check({sawRd, sawLo, sawUe}, 3'b101);
    access(1'b0, 1'b1, 20'hab126, 16'h0000, 2'h1);
    check(rspRdata, 16'hc796);
    $display("test single write done");
  endtask : t_single

  task automatic t_wait;
    waitCyc = 4'h6;
    access(1'b0, 1'b1, 20'hab120, 16'h0000, 2'h0);
    check({rdLen > ebs_pkg::STROBE_CYC, rspRdata}, {1'b1, 16'h3130});
    waitCyc = 4'h0;
    access(1'b0, 1'b1, 20'hab120, 16'h0000, 2'h0);
    check(20'(rdLen), 20'(ebs_pkg::STROBE_CYC));
    $display("test wait done");
  endtask : t_wait

  task automatic t_hold;
    int n = 0;
    busReleaseReqN = 1'b0;
    while (bus_release_ack_n !== 1'b0 && n < 80) begin @(negedge core_clk); n++; end
    tmo(n);
    repeat (3) @(negedge core_clk);
    check({bus_release_ack_n, reqReady}, 2'b00);
    busReleaseReqN = 1'b1;
    while (bus_release_ack_n !== 1'b1 && n < 80) begin @(negedge core_clk); n++; end
    tmo(n);
    $display("test hold done");
  endtask : t_hold

  task automatic t_mux;
    muxedBus = 1'b1;
    access(1'b1, 1'b1, 20'h00128, 16'h1e2d, 2'h2);
    check(sawAle, 1'b1);
    access(1'b0, 1'b1, 20'h00128, 16'h0000, 2'h2);
    check(rspRdata, 16'h1e2d);
    $display("test mux done");
  endtask : t_mux

  // second reset straps an 8-bit bus and single-chip start
  task automatic t_narrow;
    @(negedge core_clk);
    {reset_n, laneWidthPin, boot_mode_pin} = 3'b010;
    singleWrite = 1'b1;
    repeat (10) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge core_clk);
    check({narrowBus, microprocMode}, 2'b10);
    access(1'b1, 1'b0, 20'h00131, 16'h5555, 2'h3);
    check({sawLo, sawAle}, 2'b11);
    $display("test narrow done");
  endtask : t_narrow

  initial begin
    repeat (10) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge core_clk);
    t_reset();
    t_lanes();
    t_single();
    t_wait();
    t_hold();
    t_mux();
    t_narrow();
    end_sim();
  end
endmodule : ebs_bus_strobes_tb

bind ebs_bus_strobes ebs_bus_strobes_sva u_sva (.core_clk, .reset_n, .muxedBus, .narrowBus, .rspValid, .addrOut,
  .dataOut, .dataOeN, .region_select_n, .readStrobeN, .lower_lane_store_n, .upper_lane_store_n, .addrLatch,
  .bus_release_ack_n);
